//--- design/pcm_consts.svh
// Constants of the pixel colour matrix stage: widths, reset values,
// coefficient layout, preset steps and the fixed luma/chroma matrix.
// Assumes inclusion by bare name from the package and design files.
`ifndef PCM_CONSTS_SVH
`define PCM_CONSTS_SVH

// Channel width, coefficient width and fraction bits of a gain.
`define PCM_PIX_W 8
`define PCM_COEF_W 16
`define PCM_FRAC 12
`define PCM_CHAN_MAX 8'hFF

// Coefficient entries: nine gains row-major, then three offsets.
`define PCM_NCOEF 12
`define PCM_IDX_OFF 9
`define PCM_ONE 16'h1000

// Illuminant presets; the last code selects the custom bank.
`define PCM_PRESET_W 3
`define PCM_PRESET_CUSTOM 3'h7
`define PCM_PRESET_RESET 3'h0
`define PCM_PRESET_STEP 16'h0040

// White balance ratios loaded along with a preset.
`define PCM_WB_RED_BASE 16'h0100
`define PCM_WB_BLUE_BASE 16'h0200
`define PCM_WB_STEP 16'h0010

// Saturation: unity at reset, fraction bits, luma weights.
`define PCM_SAT_RESET 8'h40
`define PCM_SAT_SHIFT 6
`define PCM_Y_KR 9'h04D
`define PCM_Y_KG 9'h096
`define PCM_Y_KB 9'h01D
`define PCM_NATIVE_ON_RESET 1'b1

// Fixed luma/chroma gains and offsets.
`define PCM_YUV_G00 16'h04C9
`define PCM_YUV_G01 16'h0964
`define PCM_YUV_G02 16'h01D3
`define PCM_YUV_G10 16'hFD4D
`define PCM_YUV_G11 16'hFAB3
`define PCM_YUV_G12 16'h0800
`define PCM_YUV_G20 16'h0800
`define PCM_YUV_G21 16'hF94D
`define PCM_YUV_G22 16'hFEB3
`define PCM_YUV_OFF0 16'h0000
`define PCM_YUV_OFF12 16'h0080

`endif

//--- design/pcm_pkg.sv
// Types and shared helpers of the pixel colour matrix stage.
// Assumes the constants header sits beside this file.
`include "pcm_consts.svh"

package pcm_pkg;

    // ==========================================================
    // Types
    // ==========================================================
    typedef logic [`PCM_PIX_W-1:0] pcm_chan_t;
    typedef logic signed [`PCM_COEF_W-1:0] pcm_coef_t;
    typedef pcm_coef_t [`PCM_NCOEF-1:0] pcm_bank_t;
    typedef logic [`PCM_PRESET_W-1:0] pcm_preset_t;

    // Which transform the picker addresses.
    typedef enum logic {PCM_NATIVE, PCM_LUMA} pcm_pick_e;

    // Settings that travel with each pixel through the pipe.
    typedef struct packed {
        logic native;
        logic gamma;
        logic sat_on;
        logic [7:0] sat;
        logic yuv;
    } pcm_ctl_s;

    // One pixel beat on the stream.
    typedef struct packed {
        logic valid;
        logic sof;
        pcm_chan_t r;
        pcm_chan_t g;
        pcm_chan_t b;
    } pcm_px_s;

    // A pixel beat with its frame settings.
    typedef struct packed {
        pcm_ctl_s ctl;
        pcm_px_s px;
    } pcm_pix_s;

    // Whole state of the top module.
    typedef struct packed {
        pcm_bank_t cust;
        pcm_bank_t act;
        logic native_sw;
        logic act_valid;
        pcm_preset_t act_preset;
        pcm_ctl_s act_ctl;
        pcm_pix_s s0;
        pcm_pix_s s2;
        pcm_px_s out;
        pcm_coef_t rdback;
        logic ready;
        logic xon;
        logic [15:0] wb_red;
        logic [15:0] wb_blue;
        logic wb_load;
    } pcm_top_s;

    // Fixed luma/chroma bank, offsets in the top entries.
    localparam pcm_bank_t PCM_LUMA_BANK = {
        `PCM_YUV_OFF12, `PCM_YUV_OFF12, `PCM_YUV_OFF0,
        `PCM_YUV_G22, `PCM_YUV_G21, `PCM_YUV_G20,
        `PCM_YUV_G12, `PCM_YUV_G11, `PCM_YUV_G10,
        `PCM_YUV_G02, `PCM_YUV_G01, `PCM_YUV_G00};

    // Clamps a signed result into the channel range.
    function automatic pcm_chan_t pcm_clamp(input logic signed [31:0] v);
        if (v < 0) begin
            return '0;
        end else if (v > 32'(`PCM_CHAN_MAX)) begin
            return '1;
        end
        return v[`PCM_PIX_W-1:0];
    endfunction

endpackage

//--- design/pcm_matrix.sv
// One registered 3x3 gain plus offset stage with a bypass.
// Assumes the bank is stable for every pixel of a frame.
`timescale 1ns/10ps
`include "pcm_consts.svh"

module pcm_matrix #(
    parameter bit LUMA = 1'b0
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input pcm_pkg::pcm_bank_t bank_i,
    input pcm_pkg::pcm_pix_s pix_i,
    output pcm_pkg::pcm_pix_s pix_o
);

    // ==========================================================
    // State
    // ==========================================================
    pcm_pkg::pcm_pix_s q; // Registered output beat.
    pcm_pkg::pcm_pix_s d; // Its next value.
    logic apply; // High when this stage transforms the beat.

    // Computes one output channel from one matrix row.
    function automatic pcm_pkg::pcm_chan_t mac(
        input pcm_pkg::pcm_bank_t bk,
        input int row,
        input pcm_pkg::pcm_px_s p);
        logic signed [31:0] acc;
        acc = 32'(signed'(bk[3*row])) * 32'(signed'({1'b0, p.r}));
        acc = acc + 32'(signed'(bk[3*row+1])) * 32'(signed'({1'b0, p.g}));
        acc = acc + 32'(signed'(bk[3*row+2])) * 32'(signed'({1'b0, p.b}));
        acc = (acc >>> `PCM_FRAC)
            + 32'(signed'(bk[`PCM_IDX_OFF+row]));
        return pcm_pkg::pcm_clamp(acc);
    endfunction

    // ==========================================================
    // Next state
    // ==========================================================
    // The beat passes unchanged unless its frame enables this stage.
    always_comb begin
        apply = LUMA ? pix_i.ctl.yuv : pix_i.ctl.native;
        d = pix_i;
        if (apply && pix_i.px.valid) begin
            d.px.r = mac(bank_i, 0, pix_i.px);
            d.px.g = mac(bank_i, 1, pix_i.px);
            d.px.b = mac(bank_i, 2, pix_i.px);
        end
    end

    // Registers the stage.
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pix_o = q;

endmodule // pcm_matrix

//--- design/pcm_top.sv
// Pixel colour matrix stage: native-to-standard correction, then
// saturation and gamma, then the fixed luma/chroma conversion.
// Assumes pixels and settings come from logic on mclk_i.
//
// Contract
// - Settings usable only while pipeline is on.
// - Each pixel: 3x3 gains times RGB plus offsets.
// - Two transforms: native-to-standard and luma/chroma.
// - Native transform enable 0 bypasses, 1 applies.
// - Illuminant preset chooses stored native coefficient set.
// - Custom preset lets software load coefficient values.
// - Luma/chroma follows native matrix and gamma.
// - Luma/chroma active exactly for luma/chroma formats.
// - Coefficient value reads back entry in use.
// - Saturation enable applies saturation; larger is vivid.
// - Luma/chroma enable is read-only, follows format.
// - Picker spans nine gains and three offsets.
// - Preset also loads red and blue balance ratios.
`timescale 1ns/10ps
`include "pcm_consts.svh"

module pcm_top (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic image_pipeline_on_i,
    input pcm_pkg::pcm_pick_e transform_picker_i,
    input wire logic transform_on_i,
    input wire logic [3:0] coefficient_picker_i,
    input pcm_pkg::pcm_coef_t coefficient_value_i,
    input wire logic coefficient_wr_i,
    input pcm_pkg::pcm_preset_t illuminant_preset_i,
    input wire logic yuv_format_i,
    input wire logic gamma_on_i,
    input wire logic saturation_on_i,
    input wire logic [7:0] saturation_i,
    input pcm_pkg::pcm_px_s pix_i,
    output pcm_pkg::pcm_px_s pix_o,
    output pcm_pkg::pcm_coef_t coefficient_value_o,
    output logic transform_on_o,
    output logic controls_ready_o,
    output logic [15:0] wb_ratio_red_o,
    output logic [15:0] wb_ratio_blue_o,
    output logic wb_load_o
);

    // ==========================================================
    // State and wires
    // ==========================================================
    pcm_pkg::pcm_top_s q; // All registered state.
    pcm_pkg::pcm_top_s d; // Its next value.
    pcm_pkg::pcm_pix_s s1; // Beat after the native matrix.
    pcm_pkg::pcm_pix_s s3; // Beat after the luma/chroma matrix.
    pcm_pkg::pcm_ctl_s ctl_new; // Settings for a frame about to start.
    pcm_pkg::pcm_bank_t bank_new; // Native bank for that frame.
    logic frame_start; // First beat of a frame on the input.
    logic idx_ok; // The picker names one of the twelve entries.
    logic sw_ok; // Software controls are reachable.

    // ==========================================================
    // Helpers
    // ==========================================================
    // Stored bank of one illuminant preset: a scaled diagonal.
    function automatic pcm_pkg::pcm_bank_t preset_bank(
        input pcm_pkg::pcm_preset_t p);
        pcm_pkg::pcm_bank_t bk;
        logic [15:0] step;
        bk = '0;
        step = 16'(p * `PCM_PRESET_STEP);
        bk[0] = `PCM_ONE + step;
        bk[4] = `PCM_ONE;
        bk[8] = `PCM_ONE - step;
        return bk;
    endfunction

    // Pushes one channel away from luma by the saturation factor.
    function automatic pcm_pkg::pcm_chan_t sat_chan(
        input pcm_pkg::pcm_chan_t c,
        input pcm_pkg::pcm_chan_t y,
        input logic [7:0] s);
        logic signed [31:0] dc;
        dc = 32'(signed'({1'b0, c})) - 32'(signed'({1'b0, y}));
        dc = (dc * 32'(signed'({1'b0, s}))) >>> `PCM_SAT_SHIFT;
        return pcm_pkg::pcm_clamp(dc + 32'(signed'({1'b0, y})));
    endfunction

    // Concave curve that brightens mid tones.
    function automatic pcm_pkg::pcm_chan_t gam(
        input pcm_pkg::pcm_chan_t x);
        logic [15:0] t;
        t = 16'(x) * 16'(`PCM_CHAN_MAX - x);
        return pcm_pkg::pcm_clamp(32'(x) + 32'(t[15:8]));
    endfunction

    // Saturation then gamma on one beat, as its frame asks.
    function automatic pcm_pkg::pcm_pix_s sat_gam(
        input pcm_pkg::pcm_pix_s b);
        pcm_pkg::pcm_pix_s o;
        logic [16:0] ys;
        pcm_pkg::pcm_chan_t y;
        o = b;
        ys = 17'(`PCM_Y_KR) * b.px.r + 17'(`PCM_Y_KG) * b.px.g
           + 17'(`PCM_Y_KB) * b.px.b;
        y = ys[15:8];
        if (b.ctl.sat_on) begin
            o.px.r = sat_chan(b.px.r, y, b.ctl.sat);
            o.px.g = sat_chan(b.px.g, y, b.ctl.sat);
            o.px.b = sat_chan(b.px.b, y, b.ctl.sat);
        end
        if (b.ctl.gamma) begin
            o.px.r = gam(o.px.r);
            o.px.g = gam(o.px.g);
            o.px.b = gam(o.px.b);
        end
        return o;
    endfunction

    // ==========================================================
    // Matrix stages
    // ==========================================================
    // Native-to-standard matrix, bank held for the whole frame.
    pcm_matrix #(
        .LUMA(1'b0)
    ) u_native (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .bank_i(q.act),
        .pix_i(q.s0),
        .pix_o(s1)
    );

    // Luma/chroma matrix, last in the chain after gamma.
    pcm_matrix #(
        .LUMA(1'b1)
    ) u_luma (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .bank_i(pcm_pkg::PCM_LUMA_BANK),
        .pix_i(q.s2),
        .pix_o(s3)
    );

    // ==========================================================
    // Settings of the next frame
    // ==========================================================
    // Works out what a frame starting now will run with.
    always_comb begin
        sw_ok = image_pipeline_on_i;
        frame_start = pix_i.valid && pix_i.sof;
        idx_ok = coefficient_picker_i < 4'(`PCM_NCOEF);
        ctl_new = '0;
        if (sw_ok) begin
            ctl_new.native = q.native_sw;
            ctl_new.yuv = yuv_format_i;
            ctl_new.gamma = gamma_on_i;
            ctl_new.sat_on = saturation_on_i;
            ctl_new.sat = saturation_i;
        end
        // Custom uses the loaded bank, the rest a stored one.
        if (illuminant_preset_i == `PCM_PRESET_CUSTOM) begin
            bank_new = q.cust;
        end else begin
            bank_new = preset_bank(illuminant_preset_i);
        end
    end

    // ==========================================================
    // Next state
    // ==========================================================
    // Software side, frame latch and the pixel pipe.
    always_comb begin
        d = q;
        d.wb_load = 1'b0;
        d.ready = sw_ok;

        // The native enable is stored only while that transform
        // is picked; the luma/chroma one cannot be written.
        if (sw_ok && transform_picker_i == pcm_pkg::PCM_NATIVE) begin
            d.native_sw = transform_on_i;
        end

        // Custom entries load only under the custom preset.
        if (sw_ok && coefficient_wr_i && idx_ok
            && transform_picker_i == pcm_pkg::PCM_NATIVE
            && illuminant_preset_i == `PCM_PRESET_CUSTOM) begin
            d.cust[coefficient_picker_i] = coefficient_value_i;
        end

        // Input beat enters with the settings of its frame.
        d.s0.px = pix_i;
        d.s0.ctl = q.act_ctl;
        if (frame_start) begin
            d.act_ctl = ctl_new;
            d.s0.ctl = ctl_new;
            if (sw_ok) begin
                d.act = bank_new;
                d.act_preset = illuminant_preset_i;
                d.act_valid = 1'b1;
                // A newly chosen calibrated preset loads its ratios.
                if ((!q.act_valid || illuminant_preset_i != q.act_preset)
                    && illuminant_preset_i != `PCM_PRESET_CUSTOM) begin
                    d.wb_red = `PCM_WB_RED_BASE
                        + 16'(illuminant_preset_i * `PCM_WB_STEP);
                    d.wb_blue = `PCM_WB_BLUE_BASE
                        - 16'(illuminant_preset_i * `PCM_WB_STEP);
                    d.wb_load = 1'b1;
                end
            end
        end

        // Saturation and gamma sit between the two matrices.
        d.s2 = sat_gam(s1);
        d.out = s3.px;

        // Readback shows the entry in use by the picked transform.
        d.rdback = '0;
        if (sw_ok && idx_ok) begin
            if (transform_picker_i == pcm_pkg::PCM_LUMA) begin
                d.rdback = pcm_pkg::PCM_LUMA_BANK[coefficient_picker_i];
            end else begin
                d.rdback = q.act[coefficient_picker_i];
            end
        end

        // Enable readback of the picked transform.
        d.xon = 1'b0;
        if (sw_ok) begin
            case (transform_picker_i)
                pcm_pkg::PCM_NATIVE: begin
                    d.xon = q.native_sw;
                end
                pcm_pkg::PCM_LUMA: begin
                    d.xon = yuv_format_i;
                end
                default: begin
                    d.xon = 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    // Every piece of state is held here.
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            q <= '0;
            q.native_sw <= `PCM_NATIVE_ON_RESET;
            q.act_preset <= `PCM_PRESET_RESET;
            q.act_ctl.sat <= `PCM_SAT_RESET;
            q.wb_red <= `PCM_WB_RED_BASE;
            q.wb_blue <= `PCM_WB_BLUE_BASE;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign pix_o = q.out;
    assign coefficient_value_o = q.rdback;
    assign transform_on_o = q.xon;
    assign controls_ready_o = q.ready;
    assign wb_ratio_red_o = q.wb_red;
    assign wb_ratio_blue_o = q.wb_blue;
    assign wb_load_o = q.wb_load;

endmodule // pcm_top

//--- tb/pcm_top_props.sv
// Checker of the colour matrix stage, watching the top ports only.
// Assumes one clock domain and a five-edge pixel latency.
`timescale 1ns/10ps

module pcm_top_props (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic image_pipeline_on_i,
    input pcm_pkg::pcm_pick_e transform_picker_i,
    input wire logic transform_on_i,
    input wire logic [3:0] coefficient_picker_i,
    input wire logic yuv_format_i,
    input wire logic gamma_on_i,
    input wire logic saturation_on_i,
    input pcm_pkg::pcm_px_s pix_i,
    input pcm_pkg::pcm_px_s pix_o,
    input pcm_pkg::pcm_coef_t coefficient_value_o,
    input wire logic transform_on_o,
    input wire logic controls_ready_o,
    input wire logic [15:0] wb_ratio_red_o,
    input wire logic [15:0] wb_ratio_blue_o,
    input wire logic wb_load_o
);
    // ==========================================================
    // Helpers
    // ==========================================================
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);

    // Pipeline on with the native or the luma transform addressed.
    logic nat;
    logic lum;
    // Every stage off, so a frame must come out untouched.
    logic plain;
    assign nat = image_pipeline_on_i
        && transform_picker_i == pcm_pkg::PCM_NATIVE;
    assign lum = image_pipeline_on_i
        && transform_picker_i == pcm_pkg::PCM_LUMA;
    assign plain = nat && !transform_on_i && !gamma_on_i
        && !saturation_on_i && !yuv_format_i;

    // ==========================================================
    // Assertions
    // ==========================================================
    beat_delay_a: assert property (
        pix_i.valid && pix_i.sof |-> ##5 pix_o.valid && pix_o.sof)
        else $error("frame start beat not out after five cycles");
    native_bypass_a: assert property (
        plain ##1 (plain && pix_i.valid && pix_i.sof)
        |-> ##5 pix_o == $past(pix_i, 5))
        else $error("bypassed frame was altered");
    off_pass_a: assert property (
        !image_pipeline_on_i ##1
        (!image_pipeline_on_i && pix_i.valid && pix_i.sof)
        |-> ##5 pix_o == $past(pix_i, 5))
        else $error("frame altered while pipeline off");
    off_read_a: assert property (
        !image_pipeline_on_i [*2] |-> !controls_ready_o
        && !transform_on_o && coefficient_value_o == 16'h0000)
        else $error("controls visible while pipeline off");
    native_follow_a: assert property (
        (nat && $stable(transform_on_i)) [*3]
        |-> transform_on_o == transform_on_i)
        else $error("native enable readback wrong");
    luma_follow_a: assert property (
        (lum && $stable(yuv_format_i)) [*3]
        |-> transform_on_o == yuv_format_i)
        else $error("luma enable does not follow format");
    luma_read_a: assert property (
        (lum && coefficient_picker_i == 4'h4) [*2]
        |-> coefficient_value_o == 16'hFAB3)
        else $error("luma gain readback wrong");
    read_hold_a: assert property (
        (nat && $stable(coefficient_picker_i)
        && !(pix_i.valid && pix_i.sof)) [*4]
        |-> $stable(coefficient_value_o))
        else $error("coefficient in use changed mid frame");
    wb_pulse_a: assert property (
        wb_load_o |-> (wb_ratio_red_o + wb_ratio_blue_o == 16'h0300)
        ##1 !wb_load_o)
        else $error("balance ratio load wrong");
endmodule // pcm_top_props

bind pcm_top pcm_top_props chk_u (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .image_pipeline_on_i(image_pipeline_on_i),
    .transform_picker_i(transform_picker_i),
    .transform_on_i(transform_on_i),
    .coefficient_picker_i(coefficient_picker_i),
    .yuv_format_i(yuv_format_i),
    .gamma_on_i(gamma_on_i),
    .saturation_on_i(saturation_on_i),
    .pix_i(pix_i),
    .pix_o(pix_o),
    .coefficient_value_o(coefficient_value_o),
    .transform_on_o(transform_on_o),
    .controls_ready_o(controls_ready_o),
    .wb_ratio_red_o(wb_ratio_red_o),
    .wb_ratio_blue_o(wb_ratio_blue_o),
    .wb_load_o(wb_load_o)
);

//--- tb/pcm_src_model.sv
// Upstream pipeline stage model: sends one-beat frames on request.
// Assumes send() is called between clock edges, after a rising one.
`timescale 1ns/10ps

module pcm_src_model (
    input wire logic mclk_i,
    output pcm_pkg::pcm_px_s pix_o
);
    // Beat waiting to go out and falling edges left before it does.
    pcm_pkg::pcm_px_s beat_q;
    int pend_q = 0;
    // Idle filler changes every cycle so stale data is never seen.
    logic [7:0] junk_q = 8'h5A;

    initial pix_o = '0;

    // Queues one frame start beat after gap idle cycles.
    task automatic send(input pcm_pkg::pcm_px_s b, input int gap);
        beat_q = b;
        pend_q = gap + 1;
    endtask

    // Drives the stream on each falling edge, one beat a cycle.
    always @(negedge mclk_i) begin
        junk_q <= junk_q + 8'h35;
        pend_q <= (pend_q > 0) ? pend_q - 1 : 0;
        if (pend_q == 1) begin
            pix_o <= beat_q;
        end else begin
            pix_o <= {1'b0, 1'b0, junk_q, ~junk_q, junk_q ^ 8'h0F};
        end
    end
endmodule // pcm_src_model

//--- tb/pixel_color_matrix_transform_test.sv
// Self-checking bench of the colour matrix stage.
// Assumes the checker binds itself and the source model feeds pixels.
`timescale 1ns/10ps

module pixel_color_matrix_transform_test;
    typedef struct {
        logic [2:0] p;
        logic [7:0] r, g, b, er, eg, eb;
        logic [15:0] g0, wr, wb;
    } pcm_row_s;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic pon = 1'b0;
    pcm_pkg::pcm_pick_e pick = pcm_pkg::PCM_NATIVE;
    logic ten = 1'b1;
    logic [3:0] cpick = 4'h0;
    pcm_pkg::pcm_coef_t cval = 16'h0000;
    logic wr = 1'b0;
    pcm_pkg::pcm_preset_t preset = 3'h0;
    logic yuv = 1'b0;
    logic son = 1'b0;
    logic gam = 1'b0;
    logic [7:0] sat = 8'h40;
    pcm_pkg::pcm_px_s px_in;
    pcm_pkg::pcm_px_s px_out;
    pcm_pkg::pcm_coef_t cv_o;
    logic ton_o, rdy_o, wbl_o;
    logic [15:0] wbr_o, wbb_o;
    int err_count = 0;
    int checks = 0;
    int wbl_n = 0;

    always #2.5 mclk_i = ~mclk_i;

    // Counts the balance ratio load pulses.
    always @(posedge mclk_i) if (wbl_o === 1'b1) wbl_n <= wbl_n + 1;

    pcm_src_model src_u (.mclk_i(mclk_i), .pix_o(px_in));
    pcm_top dut_u (.mclk_i(mclk_i), .reset_i(reset_i),
        .image_pipeline_on_i(pon), .transform_picker_i(pick),
        .transform_on_i(ten), .coefficient_picker_i(cpick),
        .coefficient_value_i(cval), .coefficient_wr_i(wr),
        .illuminant_preset_i(preset), .yuv_format_i(yuv),
        .gamma_on_i(gam), .saturation_on_i(son), .saturation_i(sat),
        .pix_i(px_in), .pix_o(px_out), .coefficient_value_o(cv_o),
        .transform_on_o(ton_o), .controls_ready_o(rdy_o),
        .wb_ratio_red_o(wbr_o), .wb_ratio_blue_o(wbb_o),
        .wb_load_o(wbl_o));

    // ==========================================================
    // Tasks
    // ==========================================================
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Compares one 16-bit value.
    task automatic chk16(input logic [15:0] got, exp, input string s);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %0t: %s got %h want %h", $time, s, got, exp);
        end
    endtask

    // Compares one output pixel.
    task automatic chk_px(input pcm_pkg::pcm_px_s got,
                          input logic [7:0] r, g, b);
        checks++;
        if ({got.r, got.g, got.b} !== {r, g, b}) begin
            err_count++;
            $display("mismatch %0t: pixel got %h", $time, got);
        end
    endtask

    // Sets the frame settings at a falling edge.
    task automatic cfg(input logic o, t, input logic [2:0] p,
                       input logic y, so, input logic [7:0] s);
        @(negedge mclk_i);
        pon = o;
        ten = t;
        preset = p;
        yuv = y;
        son = so;
        sat = s;
    endtask

    // Sends a one-beat frame and checks the beat that comes out.
    task automatic frame(input logic [7:0] r, g, b, er, eg, eb,
                         input int gap);
        int n;
        @(posedge mclk_i);
        #1;
        src_u.send({1'b1, 1'b1, r, g, b}, gap);
        for (n = 0; n < 20 && px_out.valid !== 1'b1; n++) begin
            @(posedge mclk_i);
            #1;
        end
        if (n == 20) begin
            err_count++;
            $display("mismatch %0t: no output beat", $time);
            report_and_stop();
        end
        chk_px(px_out, er, eg, eb);
    endtask

    // Picks a transform and entry, then checks the readback.
    task automatic rd(input pcm_pkg::pcm_pick_e t, input logic [3:0] i,
                      input logic [15:0] e);
        @(negedge mclk_i);
        pick = t;
        cpick = i;
        repeat (3) @(posedge mclk_i);
        #1;
        chk16(cv_o, e, "readback");
    endtask

    // Writes one coefficient with a single-cycle strobe.
    task automatic wrc(input logic [3:0] i, input logic [15:0] v);
        @(negedge mclk_i);
        cpick = i;
        cval = v;
        wr = 1'b1;
        @(negedge mclk_i);
        wr = 1'b0;
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        pcm_row_s rows[3];
        logic [15:0] cust[12];
        int i;
        rows[0] = '{3'h0, 8'hC8, 8'h64, 8'h32, 8'hC8, 8'h64, 8'h32,
                    16'h1000, 16'h0100, 16'h0200};
        rows[1] = '{3'h3, 8'hC8, 8'h64, 8'h32, 8'hD1, 8'h64, 8'h2F,
                    16'h10C0, 16'h0130, 16'h01D0};
        rows[2] = '{3'h6, 8'hF0, 8'h0A, 8'h64, 8'hFF, 8'h0A, 8'h5A,
                    16'h1180, 16'h0160, 16'h01A0};
        // Swaps channels round and adds offsets 5, 0 and -2.
        cust = '{16'h0000, 16'h1000, 16'h0000, 16'h0000, 16'h0000,
                 16'h1000, 16'h1000, 16'h0000, 16'h0000, 16'h0005,
                 16'h0000, 16'hFFFE};
        repeat (12) @(posedge mclk_i);
        chk16(wbr_o, 16'h0100, "reset red");
        chk16({13'h0000, rdy_o, ton_o, wbl_o}, 16'h0000, "flags");
        @(negedge mclk_i);
        reset_i = 1'b0;
        $display("test reset done");
        // Preset rows; the partner gets slower row by row.
        for (i = 0; i < 3; i++) begin
            cfg(1'b1, 1'b1, rows[i].p, 1'b0, 1'b0, 8'h40);
            frame(rows[i].r, rows[i].g, rows[i].b, rows[i].er,
                  rows[i].eg, rows[i].eb, i);
            rd(pcm_pkg::PCM_NATIVE, 4'h0, rows[i].g0);
            chk16(wbr_o, rows[i].wr, "red ratio");
            chk16(wbb_o, rows[i].wb, "blue ratio");
        end
        chk16(16'(wbl_n), 16'h0003, "ratio loads");
        $display("test presets done");
        cfg(1'b1, 1'b0, 3'h6, 1'b0, 1'b0, 8'h40);
        frame(8'hF0, 8'h0A, 8'h64, 8'hF0, 8'h0A, 8'h64, 0);
        chk16({15'h0000, ton_o}, 16'h0000, "native off");
        cfg(1'b1, 1'b0, 3'h0, 1'b0, 1'b1, 8'h80);
        frame(8'hC8, 8'h64, 8'h32, 8'hFF, 8'h4C, 8'h00, 2);
        $display("test bypass and saturation done");
        cfg(1'b1, 1'b0, 3'h0, 1'b1, 1'b0, 8'h40);
        gam = 1'b1;
        frame(8'h40, 8'h00, 8'h00, 8'h21, 8'h6D, 8'hB7, 0);
        rd(pcm_pkg::PCM_LUMA, 4'h4, 16'hFAB3);
        chk16({14'h0000, rdy_o, ton_o}, 16'h0003, "luma on");
        cfg(1'b1, 1'b1, 3'h7, 1'b0, 1'b0, 8'h40);
        gam = 1'b0;
        rd(pcm_pkg::PCM_LUMA, 4'hB, 16'h0080);
        chk16({15'h0000, ton_o}, 16'h0000, "luma off");
        $display("test luma done");
        rd(pcm_pkg::PCM_NATIVE, 4'h1, 16'h0000);
        for (i = 0; i < 12; i++) begin
            wrc(i[3:0], cust[i]);
        end
        rd(pcm_pkg::PCM_NATIVE, 4'h0, 16'h1000);
        rd(pcm_pkg::PCM_LUMA, 4'hA, 16'h0080);
        wrc(4'hA, 16'h0007);
        frame(8'h0A, 8'h14, 8'h1E, 8'h19, 8'h1E, 8'h08, 1);
        rd(pcm_pkg::PCM_NATIVE, 4'h9, 16'h0005);
        rd(pcm_pkg::PCM_NATIVE, 4'hB, 16'hFFFE);
        $display("test custom done");
        cfg(1'b0, 1'b1, 3'h6, 1'b0, 1'b0, 8'h40);
        frame(8'hF0, 8'h0A, 8'h64, 8'hF0, 8'h0A, 8'h64, 0);
        chk16(cv_o, 16'h0000, "readback off");
        chk16({14'h0000, rdy_o, ton_o}, 16'h0000, "ready off");
        $display("test pipeline off done");
        report_and_stop();
    end
endmodule // pixel_color_matrix_transform_test
